// ### rtl/i2c_master_pkg.sv
package i2c_master_pkg;
  // Register byte offsets, one 32-bit word each
  localparam logic [4:0] OFF_STATUS = 5'h00;
  localparam logic [4:0] OFF_CONTROL = 5'h04;
  localparam logic [4:0] OFF_CONTROL_TWO = 5'h08;
  localparam logic [4:0] OFF_BUFFER = 5'h0C;
  localparam logic [4:0] OFF_RELOAD = 5'h10;
  localparam logic [4:0] OFF_FLAGS = 5'h14;
  // Status register fields
  localparam int ST_BUF_FULL = 0;
  localparam int ST_START_SEEN = 3;
  localparam int ST_STOP_SEEN = 4;
  // Control register fields
  localparam int CT_MODE_LSB = 0;
  localparam int CT_ENABLE = 5;
  localparam int CT_WRITE_COLLISION_FLAG = 7;
  // Second control register fields
  localparam int C2_START = 0;
  localparam int C2_RSTART = 1;
  localparam int C2_STOP = 2;
  localparam int C2_ACKSTAT = 6;
  localparam logic [4:0] C2_EVENT_MASK = 5'h1F;
  // Flag register fields
  localparam int FL_PORT_IRQ = 0;
  localparam int FL_BUS_COLL = 1;
  // Mode code for master operation
  localparam logic [3:0] MODE_MASTER = 4'h8;
  // Reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_CONTROL_TWO = 8'h00;
  localparam logic [7:0] RST_RELOAD = 8'h00;
  localparam logic [7:0] RST_BUFFER = 8'h00;
  // Bits per byte on the wire
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Phases per instruction cycle; second and fourth are odd phase numbers
  localparam logic [1:0] PHASE_SECOND = 2'h1;
  localparam logic [1:0] PHASE_FOURTH = 2'h3;
endpackage

// ### rtl/i2c_master_start_arbitration.sv
`timescale 1ns/10ps
module i2c_master_start_arbitration #(
  parameter int RELOAD_W = 7
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Avalon-MM register slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Two-wire bus, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Bus state
  output logic bus_free
);

  typedef enum logic [4:0] {
    S_IDLE, S_ST_WAIT, S_ST_HOLD,
    S_RS_SCL, S_RS_SDA, S_RS_RISE, S_RS_HIGH, S_RS_LOW,
    S_TX_LOW, S_TX_RISE, S_TX_HIGH,
    S_P_SDA, S_P_LOW, S_P_RISE, S_P_HIGH, S_P_FREE, S_P_END
  } state_t;

  state_t state;
  logic served;
  logic wr;
  logic [31:0] next_readdata;
  logic [7:0] control;
  logic [7:0] control_two;
  logic [7:0] transfer_buffer;
  logic [7:0] reload;
  logic [7:0] shift_register;
  logic [3:0] bitn;
  logic port_irq;
  logic bus_coll;
  logic start_seen;
  logic stop_seen;
  logic buf_full;
  logic scl_drive;
  logic sda_drive;
  logic scl_q;
  logic sda_q;
  logic start_det;
  logic stop_det;
  logic [1:0] phase;
  logic tick;
  logic [RELOAD_W-1:0] brg_cnt;
  logic brg_run;
  logic brg_load;
  logic brg_done;
  logic master_en;
  logic busy;
  logic buf_wr;
  logic tx_go;
  logic done_start;
  logic done_rs;
  logic done_stop;
  logic byte_done;
  logic coll;
  logic settle;

  // Data bit to put on the wire; released for the acknowledge slot
  function automatic logic drive_bit(input logic [7:0] sh, input logic [3:0] n);
    return (n < i2c_master_pkg::BYTE_BITS) ? ~sh[7] : 1'b0;
  endfunction

  // Bus slave: one wait cycle, then the access completes
  assign avs_waitrequest = (avs_read | avs_write) & ~served;
  assign wr = avs_write & served & avs_byteenable[0];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      served <= 1'b0;
    end else begin
      served <= (avs_read | avs_write) & ~served;
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    unique case (avs_address)
      i2c_master_pkg::OFF_STATUS: begin
        next_readdata[i2c_master_pkg::ST_BUF_FULL] = buf_full;
        next_readdata[i2c_master_pkg::ST_START_SEEN] = start_seen;
        next_readdata[i2c_master_pkg::ST_STOP_SEEN] = stop_seen;
      end
      i2c_master_pkg::OFF_CONTROL: next_readdata[7:0] = control;
      i2c_master_pkg::OFF_CONTROL_TWO: next_readdata[7:0] = control_two;
      i2c_master_pkg::OFF_BUFFER: next_readdata[7:0] = transfer_buffer;
      i2c_master_pkg::OFF_RELOAD: next_readdata[7:0] = reload;
      i2c_master_pkg::OFF_FLAGS: begin
        next_readdata[i2c_master_pkg::FL_PORT_IRQ] = port_irq;
        next_readdata[i2c_master_pkg::FL_BUS_COLL] = bus_coll;
      end
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  // Read data captured on the edge that drops waitrequest
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !served) begin
      avs_readdata <= next_readdata;
    end
  end

  assign master_en = control[i2c_master_pkg::CT_ENABLE] &&
    (control[3:0] == i2c_master_pkg::MODE_MASTER);
  assign busy = (state != S_IDLE);
  assign buf_wr = wr && (avs_address == i2c_master_pkg::OFF_BUFFER);
  // No queueing: a write while anything runs or is requested is refused
  assign tx_go = buf_wr && master_en && !busy &&
    ((control_two[4:0] & i2c_master_pkg::C2_EVENT_MASK) == 5'h00);
  assign settle = done_start | done_rs | done_stop | coll;

  // Control register; write collision set wins over software clear
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      control <= i2c_master_pkg::RST_CONTROL;
    end else begin
      if (wr && avs_address == i2c_master_pkg::OFF_CONTROL) begin
        control <= avs_writedata[7:0];
      end
      if (buf_wr && !tx_go) begin
        control[i2c_master_pkg::CT_WRITE_COLLISION_FLAG] <= 1'b1;
      end
    end
  end

  // Second control register; event bits frozen while an event runs
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      control_two <= i2c_master_pkg::RST_CONTROL_TWO;
    end else begin
      if (wr && avs_address == i2c_master_pkg::OFF_CONTROL_TWO) begin
        control_two[7] <= avs_writedata[7];
        control_two[5] <= avs_writedata[5];
        if (!busy) begin
          control_two[4:0] <= avs_writedata[4:0];
        end
      end
      if (done_start) begin
        control_two[i2c_master_pkg::C2_START] <= 1'b0;
      end
      if (done_rs) begin
        control_two[i2c_master_pkg::C2_RSTART] <= 1'b0;
      end
      if (done_stop) begin
        control_two[i2c_master_pkg::C2_STOP] <= 1'b0;
      end
      if (coll || !master_en) begin
        control_two[4:0] <= 5'h00;
      end
      if (byte_done) begin
        control_two[i2c_master_pkg::C2_ACKSTAT] <= sda_in;
      end
    end
  end

  // Buffer and reload value
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      transfer_buffer <= i2c_master_pkg::RST_BUFFER;
      reload <= i2c_master_pkg::RST_RELOAD;
    end else begin
      if (tx_go || (buf_wr && !master_en)) begin
        transfer_buffer <= avs_writedata[7:0];
      end
      if (wr && avs_address == i2c_master_pkg::OFF_RELOAD) begin
        reload <= avs_writedata[7:0];
      end
    end
  end

  // Flags: write one to clear, a coinciding hardware set wins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      port_irq <= 1'b0;
      bus_coll <= 1'b0;
    end else begin
      if (wr && avs_address == i2c_master_pkg::OFF_FLAGS) begin
        if (avs_writedata[i2c_master_pkg::FL_PORT_IRQ]) port_irq <= 1'b0;
        if (avs_writedata[i2c_master_pkg::FL_BUS_COLL]) bus_coll <= 1'b0;
      end
      if (done_start || done_rs || done_stop || byte_done) begin
        port_irq <= 1'b1;
      end
      if (stop_det && start_seen && master_en) begin
        port_irq <= 1'b1;
      end
      if (coll) begin
        bus_coll <= 1'b1;
      end
    end
  end

  // Start and stop detection from the sensed line levels
  assign start_det = scl_in && scl_q && sda_q && !sda_in;
  assign stop_det = scl_in && scl_q && !sda_q && sda_in;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (!control[i2c_master_pkg::CT_ENABLE]) begin
        start_seen <= 1'b0;
        stop_seen <= 1'b0;
      end else if (start_det) begin
        start_seen <= 1'b1;
        stop_seen <= 1'b0;
      end else if (stop_det) begin
        start_seen <= 1'b0;
        stop_seen <= 1'b1;
      end
    end
  end

  assign bus_free = stop_seen || (!start_seen && !stop_seen);

  // Buffer full: set on an accepted write, cleared after the byte
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      buf_full <= 1'b0;
    end else if (tx_go) begin
      buf_full <= 1'b1;
    end else if (byte_done || coll || !master_en) begin
      buf_full <= 1'b0;
    end
  end

  // Instruction-cycle phase counter; the generator ticks twice per cycle
  assign tick = (phase == i2c_master_pkg::PHASE_SECOND) ||
    (phase == i2c_master_pkg::PHASE_FOURTH);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // Baud rate generator: load, count down to zero, then hold stopped
  assign brg_done = brg_run && tick && (brg_cnt == '0);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      brg_cnt <= '0;
      brg_run <= 1'b0;
    end else if (brg_load) begin
      brg_cnt <= reload[RELOAD_W-1:0];
      brg_run <= 1'b1;
    end else if (!busy) begin
      brg_run <= 1'b0;
    end else if (brg_run && tick) begin
      if (brg_cnt == '0) begin
        brg_run <= 1'b0;
      end else begin
        brg_cnt <= brg_cnt - 1'b1;
      end
    end
  end

  // Bus sequencer; a load takes effect one cycle after it is asked for
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_IDLE;
      scl_drive <= 1'b0;
      sda_drive <= 1'b0;
      shift_register <= 8'h00;
      bitn <= 4'h0;
      brg_load <= 1'b0;
      done_start <= 1'b0;
      done_rs <= 1'b0;
      done_stop <= 1'b0;
      byte_done <= 1'b0;
      coll <= 1'b0;
    end else begin
      brg_load <= 1'b0;
      done_start <= 1'b0;
      done_rs <= 1'b0;
      done_stop <= 1'b0;
      byte_done <= 1'b0;
      coll <= 1'b0;
      if (!master_en) begin
        state <= S_IDLE;
        scl_drive <= 1'b0;
        sda_drive <= 1'b0;
      end else begin
        unique case (state)
          S_IDLE: begin
            if (tx_go) begin
              shift_register <= avs_writedata[7:0];
              bitn <= 4'h0;
              scl_drive <= 1'b1;
              sda_drive <= drive_bit(avs_writedata[7:0], 4'h0);
              brg_load <= 1'b1;
              state <= S_TX_LOW;
            end else if (settle) begin
              state <= S_IDLE;
            end else if (control_two[i2c_master_pkg::C2_START]) begin
              if (sda_in && scl_in) begin
                brg_load <= 1'b1;
                state <= S_ST_WAIT;
              end else if (!sda_in && !scl_in) begin
                coll <= 1'b1;
              end
            end else if (control_two[i2c_master_pkg::C2_RSTART]) begin
              scl_drive <= 1'b1;
              state <= S_RS_SCL;
            end else if (control_two[i2c_master_pkg::C2_STOP]) begin
              scl_drive <= 1'b1;
              sda_drive <= 1'b1;
              state <= S_P_SDA;
            end
          end
          S_ST_WAIT: begin
            if (!scl_in) begin
              coll <= 1'b1;
              state <= S_IDLE;
            end else if (brg_done) begin
              if (sda_in) begin
                sda_drive <= 1'b1;
                brg_load <= 1'b1;
                state <= S_ST_HOLD;
              end else begin
                coll <= 1'b1;
                state <= S_IDLE;
              end
            end
          end
          S_ST_HOLD: begin
            if (brg_done) begin
              done_start <= 1'b1;
              state <= S_IDLE;
            end
          end
          S_RS_SCL: begin
            if (!scl_in) begin
              sda_drive <= 1'b0;
              brg_load <= 1'b1;
              state <= S_RS_SDA;
            end
          end
          S_RS_SDA: begin
            if (brg_done && sda_in) begin
              scl_drive <= 1'b0;
              state <= S_RS_RISE;
            end
          end
          S_RS_RISE: begin
            if (scl_in) begin
              if (!sda_in) begin
                coll <= 1'b1;
                scl_drive <= 1'b0;
                state <= S_IDLE;
              end else begin
                brg_load <= 1'b1;
                state <= S_RS_HIGH;
              end
            end
          end
          S_RS_HIGH: begin
            if (!scl_in || !sda_in) begin
              coll <= 1'b1;
              state <= S_IDLE;
            end else if (brg_done) begin
              sda_drive <= 1'b1;
              brg_load <= 1'b1;
              state <= S_RS_LOW;
            end
          end
          S_RS_LOW: begin
            if (brg_done) begin
              done_rs <= 1'b1;
              state <= S_IDLE;
            end
          end
          S_TX_LOW: begin
            if (brg_done) begin
              scl_drive <= 1'b0;
              state <= S_TX_RISE;
            end
          end
          S_TX_RISE: begin
            if (scl_in) begin
              brg_load <= 1'b1;
              state <= S_TX_HIGH;
            end
          end
          S_TX_HIGH: begin
            if (bitn < i2c_master_pkg::BYTE_BITS && !sda_drive && !sda_in) begin
              coll <= 1'b1;
              sda_drive <= 1'b0;
              state <= S_IDLE;
            end else if (brg_done) begin
              scl_drive <= 1'b1;
              if (bitn == i2c_master_pkg::BYTE_BITS) begin
                byte_done <= 1'b1;
                sda_drive <= 1'b0;
                state <= S_IDLE;
              end else begin
                shift_register <= {shift_register[6:0], 1'b0};
                bitn <= bitn + 4'h1;
                sda_drive <= drive_bit({shift_register[6:0], 1'b0}, bitn + 4'h1);
                brg_load <= 1'b1;
                state <= S_TX_LOW;
              end
            end
          end
          S_P_SDA: begin
            if (!sda_in) begin
              brg_load <= 1'b1;
              state <= S_P_LOW;
            end
          end
          S_P_LOW: begin
            if (brg_done) begin
              scl_drive <= 1'b0;
              state <= S_P_RISE;
            end
          end
          S_P_RISE: begin
            if (scl_in) begin
              brg_load <= 1'b1;
              state <= S_P_HIGH;
            end
          end
          S_P_HIGH: begin
            if (brg_done) begin
              sda_drive <= 1'b0;
              state <= S_P_FREE;
            end
          end
          S_P_FREE: begin
            if (sda_in && scl_in) begin
              brg_load <= 1'b1;
              state <= S_P_END;
            end
          end
          S_P_END: begin
            if (brg_done) begin
              done_stop <= 1'b1;
              state <= S_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Open drain: only ever pull low or release
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_drive;
  assign sda_oe = sda_drive;

endmodule

// ### testbench/i2c_master_start_arbitration_properties.sv
`timescale 1ns/10ps
module i2c_master_start_arbitration_checker #(
  parameter int RELOAD_W = 7
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Register bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Bus lines
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic bus_free
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Request seen in its first cycle
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // Both lines left alone for a while
  sequence s_quiet;
    (!sda_oe && !scl_oe) [*8];
  endsequence
  a_one_wait: assert property (s_taken |=> !avs_waitrequest) else $error("waitrequest held too long");
  a_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > i2c_master_pkg::OFF_FLAGS
    |-> avs_readdata == 32'h00000000) else $error("unmapped read not zero");
  a_reset_free: assert property (!$past(arst_n) |-> bus_free) else $error("bus not free after reset");
  a_drain_low: assert property (scl_out == 1'b0 && sda_out == 1'b0) else $error("line driven high");
  a_start_high: assert property ($rose(sda_oe) && !scl_oe && !$past(scl_oe)
    |-> $past(scl_in) && $past(sda_in)) else $error("data pulled low without both lines high");
  a_stretch_wait: assert property (!scl_oe && !scl_in |=> !scl_oe) else $error("clock pulled during stretch");
  a_low_start_hold: assert property (avs_write && !avs_waitrequest && avs_writedata[0]
    && avs_address == i2c_master_pkg::OFF_CONTROL_TWO && !scl_in && !sda_in && !scl_oe && !sda_oe
    |=> s_quiet) else $error("start driven on a low bus");
endmodule
bind i2c_master_start_arbitration i2c_master_start_arbitration_checker #(.RELOAD_W(RELOAD_W)) u_checker (
  .sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .bus_free(bus_free));

// ### testbench/i2c_bus_slave.sv
`timescale 1ns/10ps
module i2c_bus_slave (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Sensed lines
  input wire logic scl,
  input wire logic sda,
  // Behaviour set by the bench
  input wire logic ack_en,
  input wire logic [3:0] stretch,
  // Pulls and received byte
  output logic scl_low,
  output logic sda_low,
  output logic [7:0] got
);
  logic pscl;
  logic psda;
  logic [3:0] cnt;
  logic [3:0] hold;
  // Only ever pulls low, so a released line floats to the pull-up level
  assign scl_low = hold != 4'h0;
  // One edge view of both lines drives counting, shifting, ack and stretch
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pscl <= 1'b1;
      psda <= 1'b1;
      cnt <= 4'h0;
      hold <= 4'h0;
      sda_low <= 1'b0;
      got <= 8'h00;
    end else begin
      pscl <= scl;
      psda <= sda;
      if (hold != 4'h0) hold <= hold - 4'h1;
      if (pscl && scl && psda && !sda) begin
        cnt <= 4'h0;
      end else if (!pscl && scl) begin
        if (cnt < 4'h8) got <= {got[6:0], sda};
        cnt <= cnt + 4'h1;
      end else if (pscl && !scl) begin
        sda_low <= ack_en && cnt == 4'h8;
        hold <= stretch;
        if (cnt == 4'h9) cnt <= 4'h0;
      end
    end
  end
endmodule

// ### testbench/test_i2c_master_start_arbitration.sv
`timescale 1ns/10ps
module test_i2c_master_start_arbitration;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic scl_out, scl_oe, sda_out, sda_oe, bus_free;
  logic tb_scl_low = 1'b0;
  logic tb_sda_low = 1'b0;
  logic ack_en = 1'b1;
  logic [3:0] stretch = 4'h0;
  logic slv_scl_low, slv_sda_low;
  logic [7:0] got, rd, junk, b;
  wire scl_line, sda_line;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int r, n;
  // Pull-ups: the line is low only while some party pulls it
  assign scl_line = !(scl_oe || slv_scl_low || tb_scl_low);
  assign sda_line = !(sda_oe || slv_sda_low || tb_sda_low);
  always #4 sys_clk = ~sys_clk;
  i2c_master_start_arbitration u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl_line), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .bus_free(bus_free));
  i2c_bus_slave u_slave (.sys_clk(sys_clk), .arst_n(arst_n), .scl(scl_line), .sda(sda_line), .ack_en(ack_en),
    .stretch(stretch), .scl_low(slv_scl_low), .sda_low(slv_sda_low), .got(got));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One Avalon access: held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= !w;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d, junk);
  endtask
  task automatic chk_reg(input string nm, input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 8'h00, rd);
    check(nm, rd & m, e);
  endtask
  // Polls the interrupt flag, then clears it
  task automatic wait_irq;
    int k;
    rd = 8'h00;
    for (k = 0; k < 3000 && rd[0] !== 1'b1; k++) bus(1'b0, i2c_master_pkg::OFF_FLAGS, 8'h00, rd);
    check("irq", rd[0], 1'b1);
    wr(i2c_master_pkg::OFF_FLAGS, 8'h01);
  endtask
  task automatic send(input logic [7:0] v, input logic a, input logic [3:0] s);
    ack_en <= a;
    stretch <= s;
    wr(i2c_master_pkg::OFF_BUFFER, v);
    wait_irq;
    check("byte", got, v);
    chk_reg("ack", i2c_master_pkg::OFF_CONTROL_TWO, 8'h40, {1'b0, !a, 6'h00});
    check("after", {scl_oe, sda_oe}, 2'b10);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Hang guard, well above the longest expected run
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      test_done;
    end
  end
  initial begin
    void'($urandom(1681));
    r = $urandom_range(6, 4);
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    check("free", bus_free, 1'b1);
    wr(5'h18, 8'hFF);
    for (int i = 0; i < 8; i++) chk_reg("reset", 5'(i * 4), 8'hFF, 8'h00);
    wr(i2c_master_pkg::OFF_RELOAD, 8'(r));
    wr(i2c_master_pkg::OFF_CONTROL, 8'h20 | {4'h0, i2c_master_pkg::MODE_MASTER});
    // Start, with a buffer write and event writes refused while it runs
    wr(i2c_master_pkg::OFF_CONTROL_TWO, 8'h01);
    n = 0;
    while (sda_oe !== 1'b1 && n < 500) begin
      @(posedge sys_clk);
      n++;
    end
    check("start_time", n >= 2 * r && n <= 2 * r + 8, 1'b1);
    wr(i2c_master_pkg::OFF_BUFFER, 8'hA5);
    wr(i2c_master_pkg::OFF_CONTROL_TWO, 8'h06);
    wait_irq;
    chk_reg("start_clr", i2c_master_pkg::OFF_CONTROL_TWO, 8'h1F, 8'h00);
    chk_reg("write_collision_flag", i2c_master_pkg::OFF_CONTROL, 8'h80, 8'h80);
    chk_reg("start_seen", i2c_master_pkg::OFF_STATUS, 8'h18, 8'h08);
    check("start_hold", {scl_oe, sda_oe, bus_free}, 3'b010);
    wr(i2c_master_pkg::OFF_CONTROL, 8'h28);
    // Address byte with ack, then a stretched byte with no ack
    b = {7'($urandom), 1'b0};
    send(b, 1'b1, 4'h0);
    b = {7'($urandom), 1'b1};
    send(b, 1'b0, 4'hF);
    wr(i2c_master_pkg::OFF_CONTROL_TWO, 8'h02);
    wait_irq;
    chk_reg("rs_clr", i2c_master_pkg::OFF_CONTROL_TWO, 8'h02, 8'h00);
    check("rs_hold", {scl_oe, sda_oe}, 2'b01);
    stretch <= 4'h0;
    wr(i2c_master_pkg::OFF_CONTROL_TWO, 8'h04);
    wait_irq;
    chk_reg("stop_seen", i2c_master_pkg::OFF_STATUS, 8'h18, 8'h10);
    check("stop_rel", {scl_oe, sda_oe, bus_free}, 3'b001);
    // The stop-seen flag can come a period before the stop finishes; let it finish first
    repeat (40) @(posedge sys_clk);
    chk_reg("stop_clr", i2c_master_pkg::OFF_CONTROL_TWO, 8'h04, 8'h00);
    wr(i2c_master_pkg::OFF_FLAGS, 8'h03);
    // Start on a bus held low by another party
    tb_scl_low <= 1'b1;
    tb_sda_low <= 1'b1;
    wr(i2c_master_pkg::OFF_CONTROL_TWO, 8'h01);
    repeat (20) @(posedge sys_clk);
    chk_reg("start_coll", i2c_master_pkg::OFF_FLAGS, 8'h02, 8'h02);
    chk_reg("coll_idle", i2c_master_pkg::OFF_CONTROL_TWO, 8'h01, 8'h00);
    tb_scl_low <= 1'b0;
    tb_sda_low <= 1'b0;
    wr(i2c_master_pkg::OFF_FLAGS, 8'h03);
    // Another master wins the first released data bit of a byte
    wr(i2c_master_pkg::OFF_CONTROL_TWO, 8'h01);
    wait_irq;
    wr(i2c_master_pkg::OFF_BUFFER, 8'hFF);
    n = 0;
    while (scl_oe !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    while (scl_oe !== 1'b0 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    tb_sda_low <= 1'b1;
    repeat (4) @(posedge sys_clk);
    tb_sda_low <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk_reg("tx_coll", i2c_master_pkg::OFF_FLAGS, 8'h02, 8'h02);
    check("coll_rel", {scl_oe, sda_oe}, 2'b00);
    // Disabling the port clears the bus state bits
    wr(i2c_master_pkg::OFF_CONTROL, 8'h00);
    chk_reg("disable", i2c_master_pkg::OFF_STATUS, 8'h18, 8'h00);
    check("dis_free", bus_free, 1'b1);
    test_done;
  end
endmodule
